// *** dds_pipe_pkg.sv ***
// constants and types for the dds update latency pipeline
package dds_pipe_pkg;
  localparam int unsigned SYS_CLK_MHZ = 100;
  localparam int unsigned SYNC_DIV = 4;
  localparam int unsigned SYNC_DIV_W = 2;
  localparam int unsigned FTW_W = 32;
  localparam int unsigned POW_W = 14;
  localparam int unsigned AMP_W = 10;
  localparam int unsigned PROF_W = 4;
  localparam int unsigned LAT_W = 6;
  // latencies in system clocks
  localparam logic [5:0] LAT_ST_MATCHED = 6'h1D;
  localparam logic [5:0] LAT_ST_FREQ = 6'h1D;
  localparam logic [5:0] LAT_ST_PHASE = 6'h19;
  localparam logic [5:0] LAT_ST_AMP = 6'h11;
  localparam logic [5:0] LAT_MOD_FREQ = 6'h22;
  localparam logic [5:0] LAT_MOD_PHASE = 6'h1D;
  localparam logic [5:0] LAT_MOD_AMP = 6'h15;
  localparam logic [5:0] LAT_SWP_FREQ = 6'h29;
  localparam logic [5:0] LAT_SWP_PHASE = 6'h25;
  localparam logic [5:0] LAT_SWP_AMP = 6'h1D;
  localparam int unsigned MAX_LAT = 41;
  localparam logic [31:0] RST_FTW = 32'h0000_0000;
  localparam logic [13:0] RST_POW = 14'h0000;
  localparam logic [9:0] RST_AMP = 10'h3FF;

  typedef enum logic [1:0] {
    MODE_SINGLE = 2'b00,
    MODE_MOD = 2'b01,
    MODE_SWEEP = 2'b10
  } op_mode_t;

  // pick the latency of one word kind (0 freq, 1 phase, 2 amp)
  function automatic logic [5:0] pick_lat(input op_mode_t mode, input logic matched, input logic [1:0] kind);
    logic [5:0] lat;
    lat = LAT_ST_FREQ;
    case (mode)
      MODE_MOD: lat = (kind == 2'h0) ? LAT_MOD_FREQ : (kind == 2'h1) ? LAT_MOD_PHASE : LAT_MOD_AMP;
      MODE_SWEEP: lat = (kind == 2'h0) ? LAT_SWP_FREQ : (kind == 2'h1) ? LAT_SWP_PHASE : LAT_SWP_AMP;
      default: begin
        if (matched) begin
          lat = LAT_ST_MATCHED;
        end else begin
          lat = (kind == 2'h0) ? LAT_ST_FREQ : (kind == 2'h1) ? LAT_ST_PHASE : LAT_ST_AMP;
        end
      end
    endcase
    return lat;
  endfunction : pick_lat
endpackage : dds_pipe_pkg

// *** word_delay_if.sv ***
// carrier between the trigger logic and one word delay line
`timescale 1ns/1ps
interface word_delay_if #(parameter int W = 32);
  logic load;
  logic [W-1:0] word;
  logic [5:0] lat;
  logic [W-1:0] out_word;
  logic out_strobe;
  modport ctrl (output load, output word, output lat, input out_word, input out_strobe);
  modport line (input load, input word, input lat, output out_word, output out_strobe);
endinterface : word_delay_if

// *** word_delay_line.sv ***
// programmable-latency delay line for one tuning word
`timescale 1ns/1ps
module word_delay_line
  import dds_pipe_pkg::*;
#(
  parameter int W = 32,
  parameter int DEPTH = 42,
  parameter logic [31:0] RST_VAL = 32'h0000_0000
) (
  input wire logic sys_clk, // system clock
  input wire logic reset, // async reset, high
  word_delay_if.line dl // load side and delayed output
);
  // a shift register lets each update travel independently, so back-to-back
  // commits two sync clocks apart are never merged
  logic [DEPTH-1:0] vld_ff;
  logic [W-1:0] dat_ff [DEPTH];
  logic [W-1:0] out_ff;
  logic stb_ff;

  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      vld_ff <= '0;
    end else begin
      vld_ff <= {1'b0, vld_ff[DEPTH-1:1]};
      if (dl.load) begin
        vld_ff[dl.lat - 6'h1] <= 1'b1;
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    for (int i = 0; i < DEPTH - 1; i++) begin
      dat_ff[i] <= dat_ff[i + 1];
    end
    dat_ff[DEPTH-1] <= '0;
    if (dl.load) begin
      dat_ff[dl.lat - 6'h1] <= dl.word;
    end
  end

  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      out_ff <= RST_VAL[W-1:0];
      stb_ff <= 1'b0;
    end else begin
      stb_ff <= vld_ff[0];
      if (vld_ff[0]) begin
        out_ff <= dat_ff[0];
      end
    end
  end

  assign dl.out_word = out_ff;
  assign dl.out_strobe = stb_ff;
endmodule : word_delay_line

// *** dds_update_latency_pipeline.sv ***
// update trigger, sync clock and latency pipeline of the synthesizer
`timescale 1ns/1ps
// Notes on behaviour
// (RULE1) Single tone with matched latency applies frequency, phase and amplitude together 29 clocks after commit.
// (RULE2) Single tone unmatched delivers a new frequency word 29 clocks after commit.
// (RULE3) Single tone unmatched delivers a new phase word 25 clocks after commit.
// (RULE4) Single tone unmatched delivers a new amplitude word 17 clocks after commit.
// (RULE5) Single-tone latency counts from the sync edge that samples the commit strobe and never varies.
// (RULE6) Modulation latency counts from a profile change: frequency 34, phase 29, amplitude 21.
// (RULE7) Sweep delta words take effect after 41, 37 and 29 clocks from a profile change.
// (RULE8) The host holds hard reset for at least one sync clock period.
// (RULE9) The host holds each commit pulse high for at least one sync clock period.
// (RULE10) The host changes the profile pins at most once every two sync clock periods.
// (RULE11) Hard reset returns every internal register to its default; the delay line data stages (dat_ff) have no reset.
// (RULE12) A master drives its alignment output to the slaves.
// (RULE13) A slave aligns its timing to the alignment input from the master.
// (RULE14) A commit rising edge moves the buffered words into the active registers.
// (RULE15) The sync clock runs at a quarter of the system clock and can be disabled.
// (RULE16) Commit and profile pins are sampled on the sync clock rising edge.
// (RULE17) Each latency count starts at the system clock edge after the sampling sync edge.
module dds_update_latency_pipeline
  import dds_pipe_pkg::*;
(
  input wire logic sys_clk, // system clock, 100 MHz
  input wire logic reset, // hard reset, async, high
  input wire logic commit_pin, // register-commit strobe pin
  input wire logic [PROF_W-1:0] profile_select_pins, // profile pins
  input wire op_mode_t op_mode, // operating mode
  input wire logic matched_latency, // matched latency enable
  input wire logic sync_clk_disable, // stops the sync clock output
  input wire logic is_master, // high: master, low: slave
  input wire logic align_in, // alignment input from master
  output logic align_out, // alignment output to slaves
  output logic sync_clk_out, // quarter-rate sync clock
  input wire logic [FTW_W-1:0] buf_ftw, // buffered frequency word
  input wire logic [POW_W-1:0] buf_pow, // buffered phase word
  input wire logic [AMP_W-1:0] buf_amp, // buffered amplitude word
  output logic [FTW_W-1:0] dac_ftw, // frequency word at dac data
  output logic [POW_W-1:0] dac_pow, // phase word at dac data
  output logic [AMP_W-1:0] dac_amp, // amplitude word at dac data
  output logic ftw_applied, // pulse: frequency word reached dac
  output logic pow_applied, // pulse: phase word reached dac
  output logic amp_applied // pulse: amplitude word reached dac
);
  logic [SYNC_DIV_W-1:0] div_ff;
  logic [1:0] commit_sync_ff;
  logic [2:0] align_sync_ff;
  logic [PROF_W-1:0] prof_s1_ff, prof_s2_ff, prof_smp_ff;
  logic commit_smp_ff;
  logic align_smp_ff;
  logic sync_edge;
  logic commit_rise, profile_change, trig;
  logic [FTW_W-1:0] act_ftw_ff;
  logic [POW_W-1:0] act_pow_ff;
  logic [AMP_W-1:0] act_amp_ff;
  logic trig_ff;

  word_delay_if #(.W(FTW_W)) f_if ();
  word_delay_if #(.W(POW_W)) p_if ();
  word_delay_if #(.W(AMP_W)) a_if ();

  // pin synchronisers; stage one feeds stage two only
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      commit_sync_ff <= 2'h0;
      align_sync_ff <= 3'h0;
      prof_s1_ff <= '0;
      prof_s2_ff <= '0;
    end else begin
      commit_sync_ff <= {commit_sync_ff[0], commit_pin};
      align_sync_ff <= {align_sync_ff[1:0], align_in};
      prof_s1_ff <= profile_select_pins;
      prof_s2_ff <= prof_s1_ff;
    end
  end

  // (RULE13) slave alignment restart
  // a slave restarts its divider on each rising alignment edge so all chips share sync phase
  logic align_rise;
  assign align_rise = !is_master && align_sync_ff[1] && !align_sync_ff[2];

  // (RULE15) quarter-rate divider
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      div_ff <= '0;
    end else if (align_rise) begin
      div_ff <= 2'h1;
    end else begin
      div_ff <= div_ff + 2'h1;
    end
  end

  assign sync_edge = (div_ff == 2'h0);

  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      sync_clk_out <= 1'b0;
      align_out <= 1'b0;
    end else begin
      sync_clk_out <= !sync_clk_disable && (div_ff == 2'h3 || div_ff == 2'h0);
      // (RULE12) master drives alignment
      align_out <= is_master && (div_ff == 2'h3);
    end
  end

  // (RULE16) sample on sync edge
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      commit_smp_ff <= 1'b0;
      prof_smp_ff <= '0;
    end else if (sync_edge) begin
      commit_smp_ff <= commit_sync_ff[1];
      prof_smp_ff <= prof_s2_ff;
    end
  end

  assign commit_rise = sync_edge && commit_sync_ff[1] && !commit_smp_ff;
  assign profile_change = sync_edge && (prof_s2_ff != prof_smp_ff) && (op_mode != MODE_SINGLE);
  assign trig = (op_mode == MODE_SINGLE) ? commit_rise : (commit_rise || profile_change);

  // (RULE14) commit moves buffer to active
  // (RULE11) reset restores defaults
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      act_ftw_ff <= RST_FTW;
      act_pow_ff <= RST_POW;
      act_amp_ff <= RST_AMP;
      trig_ff <= 1'b0;
    end else begin
      trig_ff <= trig;
      if (commit_rise) begin
        act_ftw_ff <= buf_ftw;
        act_pow_ff <= buf_pow;
        act_amp_ff <= buf_amp;
      end
    end
  end

  // (RULE17) count starts after sampling edge
  // (RULE5) fixed latency from trigger
  assign f_if.load = trig_ff;
  assign p_if.load = trig_ff;
  assign a_if.load = trig_ff;
  assign f_if.word = act_ftw_ff;
  assign p_if.word = act_pow_ff;
  assign a_if.word = act_amp_ff;
  // (RULE1) matched selection
  // (RULE6) modulation latencies
  // (RULE7) sweep latencies
  // the line pulses lat clocks after its load edge; the trigger flop and the load
  // edge take the other two, so the pulse lands the full latency past the sync edge
  assign f_if.lat = pick_lat(op_mode, matched_latency, 2'h0) - 6'h2;
  assign p_if.lat = pick_lat(op_mode, matched_latency, 2'h1) - 6'h2;
  assign a_if.lat = pick_lat(op_mode, matched_latency, 2'h2) - 6'h2;

  // (RULE2) frequency line
  word_delay_line #(.W(FTW_W), .DEPTH(MAX_LAT), .RST_VAL(RST_FTW)) u_ftw (
    .sys_clk(sys_clk),
    .reset(reset),
    .dl(f_if.line)
  );
  // (RULE3) phase line
  word_delay_line #(.W(POW_W), .DEPTH(MAX_LAT), .RST_VAL({18'h0, RST_POW})) u_pow (
    .sys_clk(sys_clk),
    .reset(reset),
    .dl(p_if.line)
  );
  // (RULE4) amplitude line
  word_delay_line #(.W(AMP_W), .DEPTH(MAX_LAT), .RST_VAL({22'h0, RST_AMP})) u_amp (
    .sys_clk(sys_clk),
    .reset(reset),
    .dl(a_if.line)
  );

  assign dac_ftw = f_if.out_word;
  assign dac_pow = p_if.out_word;
  assign dac_amp = a_if.out_word;
  assign ftw_applied = f_if.out_strobe;
  assign pow_applied = p_if.out_strobe;
  assign amp_applied = a_if.out_strobe;

  sequence s_trig_single;
    trig_ff && op_mode == MODE_SINGLE;
  endsequence

  property p_matched;
    @(posedge sys_clk) disable iff (reset)
    s_trig_single and matched_latency |-> ##28 (ftw_applied && pow_applied && amp_applied);
  endproperty
  a_matched: assert property (p_matched) else $error("matched words not applied together"); // (RULE1)

  property p_st_freq;
    @(posedge sys_clk) disable iff (reset)
    s_trig_single and !matched_latency |-> ##28 ftw_applied;
  endproperty
  a_st_freq: assert property (p_st_freq) else $error("single tone frequency latency wrong"); // (RULE2)

  property p_st_phase;
    @(posedge sys_clk) disable iff (reset)
    s_trig_single and !matched_latency |-> ##24 pow_applied;
  endproperty
  a_st_phase: assert property (p_st_phase) else $error("single tone phase latency wrong"); // (RULE3)

  property p_st_amp;
    @(posedge sys_clk) disable iff (reset)
    s_trig_single and !matched_latency |-> ##16 amp_applied;
  endproperty
  a_st_amp: assert property (p_st_amp) else $error("single tone amplitude latency wrong"); // (RULE4)

  property p_mod_freq;
    @(posedge sys_clk) disable iff (reset)
    trig_ff && op_mode == MODE_MOD |-> ##33 ftw_applied;
  endproperty
  a_mod_freq: assert property (p_mod_freq) else $error("modulation frequency latency wrong"); // (RULE6)

  property p_swp_freq;
    @(posedge sys_clk) disable iff (reset)
    trig_ff && op_mode == MODE_SWEEP |-> ##40 ftw_applied;
  endproperty
  a_swp_freq: assert property (p_swp_freq) else $error("sweep frequency latency wrong"); // (RULE7)

  property p_commit_load;
    @(posedge sys_clk) disable iff (reset)
    commit_rise |=> (act_ftw_ff == $past(buf_ftw) && trig_ff);
  endproperty
  a_commit_load: assert property (p_commit_load) else $error("commit did not load active words"); // (RULE14)

  property p_sync_period;
    @(posedge sys_clk) disable iff (reset)
    sync_edge && !reset && !align_rise ##1 !align_rise [*3] |=> sync_edge;
  endproperty
  a_sync_period: assert property (p_sync_period) else $error("sync period not four clocks"); // (RULE15)
endmodule : dds_update_latency_pipeline

// *** dds_host_model.sv ***
// host controller model driving commit strobe, profile pins and buffered words
`timescale 1ns/1ps
module dds_host_model
  import dds_pipe_pkg::*;
(
  input wire logic sys_clk, // system clock
  input wire logic reset, // async reset, high
  input wire logic go, // start one request
  input wire logic use_prof, // high: profile change, low: commit
  input wire logic [FTW_W-1:0] w_ftw, // next frequency word
  input wire logic [POW_W-1:0] w_pow, // next phase word
  input wire logic [AMP_W-1:0] w_amp, // next amplitude word
  output logic commit_pin, // commit strobe
  output logic [PROF_W-1:0] profile_select_pins, // profile pins
  output logic [FTW_W-1:0] buf_ftw, // buffered frequency word
  output logic [POW_W-1:0] buf_pow, // buffered phase word
  output logic [AMP_W-1:0] buf_amp, // buffered amplitude word
  output logic busy // request still running
);
  logic [3:0] cnt_ff;
  assign busy = (cnt_ff != 4'h0);
  // pulse width and spacing
  // 16-clock request slot keeps commit high 8 clocks and profile stable 16, both over the minimum
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      cnt_ff <= 4'h0;
      commit_pin <= 1'b0;
      profile_select_pins <= 4'h0;
      buf_ftw <= 32'h0000_0000;
      buf_pow <= 14'h0000;
      buf_amp <= 10'h000;
    end else if (busy) begin
      cnt_ff <= cnt_ff - 4'h1;
      if (cnt_ff == 4'h8) begin
        commit_pin <= 1'b0;
      end
    end else if (go) begin
      cnt_ff <= 4'hF;
      buf_ftw <= w_ftw;
      buf_pow <= w_pow;
      buf_amp <= w_amp;
      if (use_prof) begin
        profile_select_pins <= profile_select_pins + 4'h1;
      end else begin
        commit_pin <= 1'b1;
      end
    end
  end
endmodule : dds_host_model

// *** test_dds_update_latency_pipeline.sv ***
// self-checking bench for the update latency pipeline
`timescale 1ns/1ps
module test_dds_update_latency_pipeline
  import dds_pipe_pkg::*;
;
  logic sys_clk = 1'b0, reset = 1'b1, go = 1'b0, use_prof = 1'b0, matched_latency = 1'b0;
  logic sync_clk_disable = 1'b0, is_master = 1'b1, align_in = 1'b0, prev;
  op_mode_t op_mode = MODE_SINGLE;
  logic [31:0] w_ftw = 32'h0, rnd = 32'h0000_0051;
  logic [13:0] w_pow = 14'h0;
  logic [9:0] w_amp = 10'h0;
  logic commit_pin, ftw_applied, pow_applied, amp_applied, align_out, sync_clk_out, busy;
  logic [3:0] profile_select_pins;
  logic [31:0] buf_ftw, dac_ftw;
  logic [13:0] buf_pow, dac_pow;
  logic [9:0] buf_amp, dac_amp;
  // words of the last commit; a profile change replays them, it loads nothing new
  logic [31:0] e_ftw = 32'h0;
  logic [23:0] e_pa = {RST_POW, RST_AMP};
  int failures = 0, comparisons = 0, cyc = 0, t_f = 0, t_p = 0, t_a = 0, t0 = 0, n, m, d0;
  dds_host_model host (.sys_clk(sys_clk), .reset(reset), .go(go), .use_prof(use_prof), .w_ftw(w_ftw),
    .w_pow(w_pow), .w_amp(w_amp), .commit_pin(commit_pin), .profile_select_pins(profile_select_pins),
    .buf_ftw(buf_ftw), .buf_pow(buf_pow), .buf_amp(buf_amp), .busy(busy));
  dds_update_latency_pipeline dut (.sys_clk(sys_clk), .reset(reset), .commit_pin(commit_pin),
    .profile_select_pins(profile_select_pins), .op_mode(op_mode), .matched_latency(matched_latency),
    .sync_clk_disable(sync_clk_disable), .is_master(is_master), .align_in(align_in), .align_out(align_out),
    .sync_clk_out(sync_clk_out), .buf_ftw(buf_ftw), .buf_pow(buf_pow), .buf_amp(buf_amp), .dac_ftw(dac_ftw),
    .dac_pow(dac_pow), .dac_amp(dac_amp), .ftw_applied(ftw_applied), .pow_applied(pow_applied),
    .amp_applied(amp_applied));
  initial begin
    forever #5 sys_clk = ~sys_clk;
  end
  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction : lfsr
  // latency of word kind k (freq, phase, amp) in case c: matched, unmatched, modulation, sweep
  function automatic int exp_lat(input int c, input int k);
    int t[12] = '{29, 29, 29, 29, 25, 17, 34, 29, 21, 41, 37, 29};
    return t[c * 3 + k];
  endfunction : exp_lat
  task complete_run;
    $display("failures=%0d comparisons=%0d", failures, comparisons);
    if (failures == 0 && comparisons > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : complete_run
  task cmp_val(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      failures++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : cmp_val
  // pin-to-sync-edge phase adds a few clocks, so only a window holds here
  task cmp_rng(input int d, input int lo);
    comparisons++;
    if (d < lo || d > lo + 8) begin
      failures++;
      $display("FAIL t=%0t got=%h exp=%h", $time, d, lo);
    end
  endtask : cmp_rng
  task send(input logic prof, input int i);
    @(posedge sys_clk);
    rnd = lfsr(rnd);
    w_ftw <= (i == 0) ? 32'hFFFF_FFFF : rnd;
    rnd = lfsr(rnd);
    w_pow <= (i == 0) ? 14'h3FFF : rnd[13:0];
    w_amp <= (i == 0) ? 10'h000 : rnd[23:14];
    use_prof <= prof;
    go <= 1'b1;
    @(posedge sys_clk);
    go <= 1'b0;
    #1 t0 = cyc;
  endtask : send
  task run_case(input int c, input int i);
    op_mode <= (c == 2) ? MODE_MOD : (c == 3) ? MODE_SWEEP : MODE_SINGLE;
    matched_latency <= (c == 0);
    send(c > 1, i);
    if (c < 2) begin
      e_ftw = w_ftw;
      e_pa = {w_pow, w_amp};
    end
    n = 0;
    while (n < 90 && !(t_f > t0 && t_p > t0 && t_a > t0)) begin
      @(posedge sys_clk);
      #1 n++;
    end
    cmp_rng(t_f - t0, exp_lat(c, 0));
    cmp_val(t_f - t_p, exp_lat(c, 0) - exp_lat(c, 1));
    cmp_val(t_f - t_a, exp_lat(c, 0) - exp_lat(c, 2));
    cmp_val(dac_ftw, e_ftw);
    cmp_val({dac_pow, dac_amp}, e_pa);
  endtask : run_case
  task count_clk;
    n = 0;
    m = 0;
    repeat (16) begin
      @(posedge sys_clk);
      #1 n += (sync_clk_out === 1'b1);
      m += (align_out === 1'b1);
    end
  endtask : count_clk
  task reset_check;
    repeat (6) @(posedge sys_clk);
    #1 cmp_val(dac_ftw, RST_FTW);
    cmp_val(dac_amp, RST_AMP);
    cmp_val({dac_pow, sync_clk_out, align_out, ftw_applied, pow_applied, amp_applied}, 0);
    @(posedge sys_clk);
    reset <= 1'b0;
    repeat (4) @(posedge sys_clk);
  endtask : reset_check
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    if (ftw_applied === 1'b1) t_f <= cyc;
    if (pow_applied === 1'b1) t_p <= cyc;
    if (amp_applied === 1'b1) t_a <= cyc;
    if (cyc == 20000) begin
      failures++;
      complete_run();
    end
  end
  initial begin
    reset_check();
    count_clk();
    cmp_val(n, 8);
    cmp_val(m, 4);
    sync_clk_disable <= 1'b1;
    is_master <= 1'b0;
    count_clk();
    cmp_val(n, 0);
    cmp_val(m, 0);
    sync_clk_disable <= 1'b0;
    // gap between the two alignment pulses is not a multiple of four clocks
    for (int k = 0; k < 2; k++) begin
      repeat (k + 1) @(posedge sys_clk);
      align_in <= 1'b1;
      // skip the clocks before a restart can show, so a free-running rise is not taken
      repeat (4) @(posedge sys_clk);
      #1 n = 4;
      prev = 1'b1;
      while (n < 20 && !(sync_clk_out === 1'b1 && prev === 1'b0)) begin
        prev = sync_clk_out;
        @(posedge sys_clk);
        #1 n++;
      end
      if (k == 0) d0 = n;
      align_in <= 1'b0;
      repeat (7) @(posedge sys_clk);
    end
    cmp_val(n, d0);
    is_master <= 1'b1;
    for (int c = 0; c < 4; c++) begin
      for (int i = 0; i < 3; i++) begin
        rnd = lfsr(rnd);
        repeat (rnd[1:0]) @(posedge sys_clk);
        run_case(c, i);
      end
    end
    op_mode <= MODE_SINGLE;
    send(1'b1, 1);
    repeat (60) @(posedge sys_clk);
    cmp_val(t_f > t0, 0);
    reset <= 1'b1;
    reset_check();
    run_case(1, 1);
    complete_run();
  end
endmodule : test_dds_update_latency_pipeline
